//--- mfs_pkg.sv
`default_nettype none
package mfs_pkg;

  // register offsets on the control port
  localparam logic [7:0] OFS_INPUT_OV_LIVE   = 8'h35;
  localparam logic [7:0] OFS_BIAS_LIVE       = 8'h37;
  localparam logic [7:0] OFS_BIAS_OV_CFG     = 8'h55;
  localparam logic [7:0] OFS_MON_DATA_CFG    = 8'h59;
  localparam logic [7:0] OFS_BATT_MON_UPPER  = 8'h5A;
  localparam logic [7:0] OFS_BATT_MON_LOWER  = 8'h5B;

  // reset values
  localparam logic [7:0] RST_INPUT_OV_LIVE   = 8'h00;
  localparam logic [7:0] RST_BIAS_LIVE       = 8'h00;
  localparam logic [7:0] RST_BIAS_OV_CFG     = 8'h40;
  localparam logic [7:0] RST_MON_DATA_CFG    = 8'h00;
  localparam logic [7:0] RST_BATT_MON_UPPER  = 8'h00;
  localparam logic [7:0] RST_BATT_MON_LOWER  = 8'h00;
  localparam logic [2:0] RST_MARGIN_CODE     = 3'h2;
  localparam logic [3:0] RST_SOURCE_TAG      = 4'h0;

  // field positions
  localparam int BIT_CH1_OV        = 7;
  localparam int BIT_CH2_OV        = 6;
  localparam int BIT_BIAS_HI_CUR   = 7;
  localparam int BIT_BIAS_LO_CUR   = 6;
  localparam int BIT_BIAS_OV       = 5;
  localparam int MARGIN_MSB        = 7;
  localparam int MARGIN_LSB        = 5;
  localparam int CFG_SPARE_MSB     = 7;
  localparam int CFG_SPARE_LSB     = 4;
  localparam int BIT_FREEZE        = 0;
  localparam int MON_RESULT_W      = 12;

  // margin above programmed bias voltage, in mV
  localparam logic [7:0] MARGIN_STEP_MV = 8'h1E;
  localparam logic [7:0] MARGIN_1_MV    = 8'h0A;
  localparam logic [7:0] MARGIN_2_MV    = 8'h28;

  function automatic logic [7:0] mfs_margin_mv(input logic [2:0] code);
    logic [7:0] mv;
    mv = 8'h00;
    case (code)
      3'h0: mv = 8'h00;
      3'h1: mv = MARGIN_1_MV;
      default: mv = 8'(MARGIN_2_MV + MARGIN_STEP_MV * 8'(code - 3'h2));
    endcase
    return mv;
  endfunction

endpackage
`default_nettype wire

//--- mfs_monitor_capture.sv
`timescale 1ns/1ps
`default_nettype none
module mfs_monitor_capture
  import mfs_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // control
  input  wire logic                    freeze,
  // conversion results from the diagnostic converter
  input  wire logic                    mon_valid,
  input  wire logic [MON_RESULT_W-1:0] mon_result,
  input  wire logic [3:0]              mon_source_tag,
  // captured bytes
  output logic      [7:0]              upper_byte,
  output logic      [7:0]              lower_byte
);

  logic [7:0] upper_r;
  logic [7:0] lower_r;

  // both bytes load from one word, so a frozen pair is coherent
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_r <= RST_BATT_MON_UPPER;
      lower_r <= RST_BATT_MON_LOWER;
    end else if (mon_valid && !freeze) begin
      upper_r <= mon_result[11:4];
      lower_r <= {mon_result[3:0], mon_source_tag};
    end
  end

  assign upper_byte = upper_r;
  assign lower_byte = lower_r;

  property p_frozen_pair;
    @(posedge clk) disable iff (!rst_n)
    freeze |=> ($stable(upper_r) && $stable(lower_r));
  endproperty
  a_frozen_pair: assert property (p_frozen_pair) else $error("monitor bytes moved while frozen");

  property p_live_load;
    @(posedge clk) disable iff (!rst_n)
    (mon_valid && !freeze) |=> (upper_r == $past(mon_result[11:4])) && (lower_r[7:4] == $past(mon_result[3:0]));
  endproperty
  a_live_load: assert property (p_live_load) else $error("monitor bytes not updated");

endmodule
`default_nettype wire

//--- mfs_fault_regs.sv
// Contract
// - Overvoltage status bit 7 shows channel one positive input overvoltage live.
// - Overvoltage status bit 6 shows channel two positive input overvoltage live.
// - Bias status bit 7 shows bias-supply high-current fault live.
// - Bias status bit 6 shows bias-supply low-current fault live.
// - Bias status bit 5 shows bias-supply overvoltage fault live.
// - Live status registers are read-only, report current faults, reset to zero.
// - Margin code 0 none, 1 10 mV, 2 40 mV, 7 190 mV.
// - Codes 3 to 6 step 30 mV; field resets to 2, register 0x40.
// - Freeze bit clear updates monitor data continuously; set holds it.
// - Register 0x5A holds upper eight battery monitor bits, read-only, resets zero.
// - Next register holds low four result bits above four-bit source tag.
`timescale 1ns/1ps
`default_nettype none
module mfs_fault_regs
  import mfs_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // register port
  input  wire logic [7:0]              reg_addr,
  input  wire logic                    reg_wr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  output logic                         reg_rd_valid,
  // fault detector levels
  input  wire logic                    ch1_positive_input_ov,
  input  wire logic                    ch2_positive_input_ov,
  input  wire logic                    bias_high_current,
  input  wire logic                    bias_low_current,
  input  wire logic                    bias_overvoltage,
  // diagnostic converter results
  input  wire logic                    mon_valid,
  input  wire logic [MON_RESULT_W-1:0] mon_result,
  input  wire logic [3:0]              mon_source_tag,
  // configuration to analog and converter
  output logic      [2:0]              bias_overvoltage_margin,
  output logic      [7:0]              bias_overvoltage_margin_mv,
  output logic                         freeze_monitor_update
);

  logic [7:0] input_overvoltage_live_status_r;
  logic [7:0] bias_supply_live_status_r;
  logic [2:0] margin_r;
  logic [3:0] cfg_spare_r;
  logic       freeze_r;
  logic [7:0] upper_byte;
  logic [7:0] lower_byte;
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic       rd_valid_r;

  function automatic logic wr_hit(input logic [7:0] ofs);
    return reg_wr && (reg_addr == ofs);
  endfunction

  // live status: sampled every cycle, no latching
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      input_overvoltage_live_status_r <= RST_INPUT_OV_LIVE;
      bias_supply_live_status_r       <= RST_BIAS_LIVE;
    end else begin
      input_overvoltage_live_status_r             <= 8'h00;
      input_overvoltage_live_status_r[BIT_CH1_OV] <= ch1_positive_input_ov;
      input_overvoltage_live_status_r[BIT_CH2_OV] <= ch2_positive_input_ov;
      bias_supply_live_status_r                  <= 8'h00;
      bias_supply_live_status_r[BIT_BIAS_HI_CUR] <= bias_high_current;
      bias_supply_live_status_r[BIT_BIAS_LO_CUR] <= bias_low_current;
      bias_supply_live_status_r[BIT_BIAS_OV]     <= bias_overvoltage;
    end
  end

  // bias overvoltage margin configuration
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      margin_r <= RST_MARGIN_CODE;
    end else if (wr_hit(OFS_BIAS_OV_CFG)) begin
      margin_r <= reg_wdata[MARGIN_MSB:MARGIN_LSB];
    end
  end

  // monitor data configuration
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_spare_r <= RST_MON_DATA_CFG[CFG_SPARE_MSB:CFG_SPARE_LSB];
      freeze_r    <= RST_MON_DATA_CFG[BIT_FREEZE];
    end else if (wr_hit(OFS_MON_DATA_CFG)) begin
      cfg_spare_r <= reg_wdata[CFG_SPARE_MSB:CFG_SPARE_LSB];
      freeze_r    <= reg_wdata[BIT_FREEZE];
    end
  end

  assign bias_overvoltage_margin    = margin_r;
  assign bias_overvoltage_margin_mv = mfs_margin_mv(margin_r);
  assign freeze_monitor_update      = freeze_r;

  mfs_monitor_capture u_capture (
    .clk            (clk),
    .rst_n          (rst_n),
    .freeze         (freeze_r),
    .mon_valid      (mon_valid),
    .mon_result     (mon_result),
    .mon_source_tag (mon_source_tag),
    .upper_byte     (upper_byte),
    .lower_byte     (lower_byte)
  );

  // read mux; reserved bits and unmapped offsets read zero
  always_comb begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      OFS_INPUT_OV_LIVE:  rdata_nxt = input_overvoltage_live_status_r;
      OFS_BIAS_LIVE:      rdata_nxt = bias_supply_live_status_r;
      OFS_BIAS_OV_CFG:    rdata_nxt = {margin_r, 5'h00};
      OFS_MON_DATA_CFG:   rdata_nxt = {cfg_spare_r, 3'h0, freeze_r};
      OFS_BATT_MON_UPPER: rdata_nxt = upper_byte;
      OFS_BATT_MON_LOWER: rdata_nxt = lower_byte;
      default:            rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= reg_rd;
    end
  end

  assign reg_rdata    = rdata_r;
  assign reg_rd_valid = rd_valid_r;

  property p_ch1_ov;
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_INPUT_OV_LIVE && $past(rst_n)) |=>
      reg_rdata[BIT_CH1_OV] == $past(ch1_positive_input_ov, 2);
  endproperty
  a_ch1_ov: assert property (p_ch1_ov) else $error("ch1 overvoltage bit wrong");

  property p_ch2_ov;
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_INPUT_OV_LIVE && $past(rst_n)) |=>
      reg_rdata[BIT_CH2_OV] == $past(ch2_positive_input_ov, 2);
  endproperty
  a_ch2_ov: assert property (p_ch2_ov) else $error("ch2 overvoltage bit wrong");

  property p_bias_hi;
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_BIAS_LIVE && $past(rst_n)) |=>
      reg_rdata[BIT_BIAS_HI_CUR] == $past(bias_high_current, 2);
  endproperty
  a_bias_hi: assert property (p_bias_hi) else $error("high current bit wrong");

  property p_bias_lo;
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_BIAS_LIVE && $past(rst_n)) |=>
      reg_rdata[BIT_BIAS_LO_CUR] == $past(bias_low_current, 2);
  endproperty
  a_bias_lo: assert property (p_bias_lo) else $error("low current bit wrong");

  property p_bias_ov;
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_BIAS_LIVE && $past(rst_n)) |=>
      reg_rdata[BIT_BIAS_OV] == $past(bias_overvoltage, 2);
  endproperty
  a_bias_ov: assert property (p_bias_ov) else $error("bias overvoltage bit wrong");

  property p_live_ro;
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && (reg_addr == OFS_INPUT_OV_LIVE || reg_addr == OFS_BIAS_LIVE)) |=>
      (reg_rdata[4:0] == 5'h00) && ($past(reg_addr) != OFS_INPUT_OV_LIVE || reg_rdata[5] == 1'b0);
  endproperty
  a_live_ro: assert property (p_live_ro) else $error("reserved live bits nonzero");

  property p_margin_ends;
    @(posedge clk) disable iff (!rst_n)
    (margin_r == 3'h0 |-> bias_overvoltage_margin_mv == 8'h00) and
    (margin_r == 3'h1 |-> bias_overvoltage_margin_mv == 8'h0A) and
    (margin_r == 3'h7 |-> bias_overvoltage_margin_mv == 8'hBE);
  endproperty
  a_margin_ends: assert property (p_margin_ends) else $error("margin end codes wrong");

  property p_margin_steps;
    @(posedge clk) disable iff (!rst_n)
    (margin_r == 3'h2 |-> bias_overvoltage_margin_mv == 8'h28) and
    (margin_r == 3'h4 |-> bias_overvoltage_margin_mv == 8'h64) and
    (margin_r == 3'h6 |-> bias_overvoltage_margin_mv == 8'hA0);
  endproperty
  a_margin_steps: assert property (p_margin_steps) else $error("margin step wrong");

  property p_margin_write;
    @(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == OFS_BIAS_OV_CFG) ##1 (reg_rd && reg_addr == OFS_BIAS_OV_CFG && !reg_wr) |=>
      reg_rdata == {$past(reg_wdata[7:5], 2), 5'h00};
  endproperty
  a_margin_write: assert property (p_margin_write) else $error("margin readback wrong");

  property p_freeze_write;
    @(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == OFS_MON_DATA_CFG) |=> freeze_monitor_update == $past(reg_wdata[0]);
  endproperty
  a_freeze_write: assert property (p_freeze_write) else $error("freeze control not written");

  property p_upper_read;
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_BATT_MON_UPPER) |=> reg_rdata == $past(upper_byte);
  endproperty
  a_upper_read: assert property (p_upper_read) else $error("upper monitor byte readback wrong");

  property p_lower_tag;
    @(posedge clk) disable iff (!rst_n)
    (mon_valid && !freeze_r) ##1 (reg_rd && reg_addr == OFS_BATT_MON_LOWER && !mon_valid) |=>
      reg_rdata == {$past(mon_result[3:0], 2), $past(mon_source_tag, 2)};
  endproperty
  a_lower_tag: assert property (p_lower_tag) else $error("lower monitor byte layout wrong");

  property p_upper_fresh;
    @(posedge clk) disable iff (!rst_n)
    (mon_valid && !freeze_r) ##1 (reg_rd && reg_addr == OFS_BATT_MON_UPPER && !mon_valid) |=>
      reg_rdata == $past(mon_result[11:4], 2);
  endproperty
  a_upper_fresh: assert property (p_upper_fresh) else $error("upper monitor byte not from last word");

  property p_reset_state;
    @(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> ({margin_r, 5'h00} == RST_BIAS_OV_CFG) && !reg_rd_valid && (reg_rdata == 8'h00) &&
      ({cfg_spare_r, 3'h0, freeze_r} == RST_MON_DATA_CFG);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("config not at reset value after reset");

  property p_reset_live;
    @(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> (input_overvoltage_live_status_r == RST_INPUT_OV_LIVE) &&
      (bias_supply_live_status_r == RST_BIAS_LIVE);
  endproperty
  a_reset_live: assert property (p_reset_live) else $error("live status not zero after reset");

  property p_reset_mon;
    @(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> (upper_byte == RST_BATT_MON_UPPER) && (lower_byte == RST_BATT_MON_LOWER);
  endproperty
  a_reset_mon: assert property (p_reset_mon) else $error("monitor bytes not zero after reset");

  property p_live_reserved;
    @(posedge clk) disable iff (!rst_n)
    (input_overvoltage_live_status_r[5:0] == 6'h00) && (bias_supply_live_status_r[4:0] == 5'h00);
  endproperty
  a_live_reserved: assert property (p_live_reserved) else $error("reserved live status bits set");

  property p_margin_load;
    @(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == OFS_BIAS_OV_CFG) |=> bias_overvoltage_margin == $past(reg_wdata[MARGIN_MSB:MARGIN_LSB]);
  endproperty
  a_margin_load: assert property (p_margin_load) else $error("margin code not written");

  property p_margin_hold;
    @(posedge clk) disable iff (!rst_n)
    !(reg_wr && reg_addr == OFS_BIAS_OV_CFG) |=> $stable(bias_overvoltage_margin);
  endproperty
  a_margin_hold: assert property (p_margin_hold) else $error("margin code moved without write");

  property p_margin_odd;
    @(posedge clk) disable iff (!rst_n)
    (margin_r == 3'h3 |-> bias_overvoltage_margin_mv == 8'h46) and
    (margin_r == 3'h5 |-> bias_overvoltage_margin_mv == 8'h82);
  endproperty
  a_margin_odd: assert property (p_margin_odd) else $error("margin odd step wrong");

  property p_margin_read;
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_BIAS_OV_CFG) |=> reg_rdata == {$past(bias_overvoltage_margin), 5'h00};
  endproperty
  a_margin_read: assert property (p_margin_read) else $error("margin register readback wrong");

  property p_freeze_hold;
    @(posedge clk) disable iff (!rst_n)
    !(reg_wr && reg_addr == OFS_MON_DATA_CFG) |=> $stable(freeze_monitor_update);
  endproperty
  a_freeze_hold: assert property (p_freeze_hold) else $error("freeze control moved without write");

  property p_cfg_read;
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_MON_DATA_CFG) |=>
      reg_rdata == {$past(cfg_spare_r), 3'h0, $past(freeze_monitor_update)};
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("monitor config readback wrong");

  property p_spare_write;
    @(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == OFS_MON_DATA_CFG) |=> cfg_spare_r == $past(reg_wdata[CFG_SPARE_MSB:CFG_SPARE_LSB]);
  endproperty
  a_spare_write: assert property (p_spare_write) else $error("monitor config upper bits not stored");

  property p_rd_answer;
    @(posedge clk) disable iff (!rst_n)
    reg_rd |=> reg_rd_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");

  property p_rdata_hold;
    @(posedge clk) disable iff (!rst_n)
    !reg_rd |=> $stable(reg_rdata) && !reg_rd_valid;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");

endmodule
`default_nettype wire

//--- mfs_fault_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module mfs_fault_regs_test;
  import mfs_pkg::*;

  logic                    clk;
  logic                    rst_n;
  logic [7:0]              reg_addr;
  logic                    reg_wr;
  logic [7:0]              reg_wdata;
  logic                    reg_rd;
  logic [7:0]              reg_rdata;
  logic                    reg_rd_valid;
  logic [4:0]              flt;
  logic                    mon_valid;
  logic [MON_RESULT_W-1:0] mon_result;
  logic [3:0]              mon_source_tag;
  logic [2:0]              margin;
  logic [7:0]              margin_mv;
  logic                    freeze;
  int                      mismatches;
  int                      n_checks;
  logic [7:0]              mv_exp [8];
  logic [4:0]              f;

  mfs_fault_regs uut (
    .clk                        (clk),
    .rst_n                      (rst_n),
    .reg_addr                   (reg_addr),
    .reg_wr                     (reg_wr),
    .reg_wdata                  (reg_wdata),
    .reg_rd                     (reg_rd),
    .reg_rdata                  (reg_rdata),
    .reg_rd_valid               (reg_rd_valid),
    .ch1_positive_input_ov      (flt[4]),
    .ch2_positive_input_ov      (flt[3]),
    .bias_high_current          (flt[2]),
    .bias_low_current           (flt[1]),
    .bias_overvoltage           (flt[0]),
    .mon_valid                  (mon_valid),
    .mon_result                 (mon_result),
    .mon_source_tag             (mon_source_tag),
    .bias_overvoltage_margin    (margin),
    .bias_overvoltage_margin_mv (margin_mv),
    .freeze_monitor_update      (freeze)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic final_report();
    if (mismatches == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clk);
    #1;
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk);
    #1;
    reg_rd   = 1'b0;
    chk("rd_valid", 8'h01, {7'h00, reg_rd_valid});
    chk(nm, exp, reg_rdata);
  endtask

  // one conversion word, then the bus shows garbage
  task automatic mon(input logic [11:0] r, input logic [3:0] t);
    @(posedge clk);
    #1;
    mon_valid      = 1'b1;
    mon_result     = r;
    mon_source_tag = t;
    @(posedge clk);
    #1;
    mon_valid      = 1'b0;
    mon_result     = ~r;
    mon_source_tag = ~t;
  endtask

  // write, then read on the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp, input string nm);
    @(posedge clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clk);
    #1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b1;
    @(posedge clk);
    #1;
    reg_rd    = 1'b0;
    chk(nm, exp, reg_rdata);
  endtask

  // read and write in one cycle: read sees the old value
  task automatic rd_wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp, input string nm);
    @(posedge clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    reg_rd    = 1'b1;
    @(posedge clk);
    #1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    chk("rd_valid", 8'h01, {7'h00, reg_rd_valid});
    chk(nm, exp, reg_rdata);
  endtask

  // conversion word, then a read on the very next edge
  task automatic mon_rd(input logic [11:0] r, input logic [3:0] t, input logic [7:0] a,
                        input logic [7:0] exp, input string nm);
    @(posedge clk);
    #1;
    mon_valid      = 1'b1;
    mon_result     = r;
    mon_source_tag = t;
    @(posedge clk);
    #1;
    mon_valid      = 1'b0;
    mon_result     = ~r;
    mon_source_tag = ~t;
    reg_addr       = a;
    reg_rd         = 1'b1;
    @(posedge clk);
    #1;
    reg_rd         = 1'b0;
    chk(nm, exp, reg_rdata);
  endtask

  task automatic reset_checks();
    chk("margin", {5'h00, RST_MARGIN_CODE}, {5'h00, margin});
    chk("margin_mv", 8'h28, margin_mv);
    chk("freeze", 8'h00, {7'h00, freeze});
    rd(8'h35, 8'h00, "ov_live");
    rd(8'h37, 8'h00, "bias_live");
    rd(8'h55, 8'h40, "ov_cfg");
    rd(8'h59, 8'h00, "mon_cfg");
    rd(8'h5A, 8'h00, "mon_upper");
    rd(8'h5B, 8'h00, "mon_lower");
  endtask

  initial begin
    #50000;
    mismatches++;
    final_report();
  end

  initial begin
    mv_exp = '{8'h00, 8'h0A, 8'h28, 8'h46, 8'h64, 8'h82, 8'hA0, 8'hBE};
    mismatches = 0;
    n_checks = 0;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    flt = 5'h00;
    mon_valid = 1'b0;
    mon_result = 12'h000;
    mon_source_tag = 4'h0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    reset_checks();
    // each fault alone, then all, then none
    for (int i = 0; i <= 6; i++) begin
      f = (i < 5) ? 5'(1 << i) : ((i == 5) ? 5'h1F : 5'h00);
      flt = f;
      rd(8'h35, {f[4], f[3], 6'h00}, "ov_live");
      rd(8'h37, {f[2:0], 5'h00}, "bias_live");
    end
    flt = 5'h1F;
    wr(8'h35, 8'h00);
    wr(8'h37, 8'h00);
    rd(8'h35, 8'hC0, "ov_live_ro");
    rd(8'h37, 8'hE0, "bias_live_ro");
    flt = 5'h00;
    wr(8'h36, 8'hFF);
    rd(8'h36, 8'h00, "unmapped");
    for (int c = 0; c < 8; c++) begin
      wr(8'h55, {3'(c), 5'h00});
      chk("margin", 8'(c), {5'h00, margin});
      chk("margin_mv", mv_exp[c], margin_mv);
      rd(8'h55, {3'(c), 5'h00}, "ov_cfg");
    end
    rd_wr(8'h55, 8'h20, 8'hE0, "rd_wr_old");
    rd(8'h55, 8'h20, "rd_wr_new");
    wr_rd(8'h55, 8'h40, 8'h40, "wr_rd");
    mon(12'hABC, 4'h0);
    rd(8'h5A, 8'hAB, "mon_upper");
    rd(8'h5B, 8'hC0, "mon_lower");
    wr(8'h59, 8'h01);
    chk("freeze", 8'h01, {7'h00, freeze});
    rd(8'h59, 8'h01, "mon_cfg");
    mon(12'h5E7, 4'h9);
    rd(8'h5A, 8'hAB, "frozen_upper");
    mon(12'h123, 4'h3);
    rd(8'h5B, 8'hC0, "frozen_lower");
    wr(8'h59, 8'h00);
    rd(8'h5A, 8'hAB, "no_queue_upper");
    mon(12'h5E7, 4'h9);
    rd(8'h5B, 8'h79, "live_lower");
    rd(8'h5A, 8'h5E, "live_upper");
    mon_rd(12'hD42, 4'h6, 8'h5B, 8'h26, "fresh_lower");
    mon_rd(12'h817, 4'hA, 8'h5A, 8'h81, "fresh_upper");
    // second reset in mid-run with non-default state
    wr(8'h55, 8'hE0);
    wr(8'h59, 8'h01);
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    reset_checks();
    final_report();
  end
endmodule
`default_nettype wire
